// ===== hdl/cbfe_card.sv
// Purpose: Card end: bus mode lock, command receive, response send
// Assumes: Host clock far slower than sys_clk (half period >= 8 cycles)
// Notes: Flash back end sits on the user side; only framing handled here
`timescale 1ns/10ps
`default_nettype none
module cbfe_card #(
    parameter int READY_POLLS = 2
) (
    input wire logic sys_clk,
    input wire logic nrst,
    cbfe_link_if.card link,
    input wire logic vdd_ok,
    input wire logic prog_busy,
    output logic cmd_valid,
    output logic [5:0] cmd_index,
    output logic [31:0] cmd_arg,
    output var cbfe_pkg::cbfe_mode_t bus_mode,
    output logic bus_wide,
    output logic [2:0] speed_mode,
    output logic card_ready
);
    cbfe_pkg::cbfe_mode_t mode;
    logic [1:0] sclk_s;
    logic [1:0] cmd_s;
    logic [1:0] cs_s;
    logic [1:0] vdd_s;
    logic sclk_q;
    logic vdd_q;
    logic [46:0] rx_shift;
    logic [5:0] rx_cnt;
    logic rx_on;
    logic [2:0] bitpos;
    logic app_cmd;
    logic [7:0] polls;
    logic cd_pull_en;
    logic busy_q;
    logic [47:0] tx_shift;
    logic [5:0] tx_left;
    logic tx_bit;
    logic tx_drive;

    wire rise = sclk_s[1] & ~sclk_q;
    wire fall = ~sclk_s[1] & sclk_q;
    wire line = cmd_s[1];
    wire cs_n = cs_s[1];
    wire spi = mode == cbfe_pkg::CBFE_SPI;
    // Recovery after a supply drop acts like power-up
    wire power_back = vdd_s[1] & ~vdd_q;
    wire core_rst = ~nrst | power_back;
    wire deselected = spi & cs_n;
    wire tx_busy = tx_left != 6'h00 || tx_drive;

    // Receive framing
    wire rx_start = rise & ~rx_on & ~tx_busy & ~line & (~spi | bitpos == 3'h0);
    wire rx_last = rise & rx_on & rx_cnt == cbfe_pkg::FRAME_BITS - 6'h01;
    wire [47:0] frame = {rx_shift, line};
    wire frame_ok = rx_last & frame[46] & frame[0];
    wire [5:0] idx = frame[45:40];
    wire [31:0] arg = frame[39:8];

    // Command decode
    wire is_reset = ~app_cmd & idx == cbfe_pkg::CMD_RESET;
    wire is_init = app_cmd ? idx == cbfe_pkg::ACMD_OP_COND : idx == cbfe_pkg::CMD_OP_COND1;
    wire is_width = app_cmd & idx == cbfe_pkg::ACMD_BUS_WIDTH & ~spi & card_ready;
    wire is_cd = app_cmd & idx == cbfe_pkg::ACMD_CARD_DETECT;
    wire is_bcast = ~app_cmd & (idx == cbfe_pkg::CMD_SEND_ID || idx == cbfe_pkg::CMD_REL_ADDR);
    wire is_switch = ~app_cmd & idx == cbfe_pkg::CMD_SWITCH & arg[31] & arg[3:0] <= cbfe_pkg::SPEED_MAX;
    wire to_spi = mode == cbfe_pkg::CBFE_SD_OPEN & is_reset & ~cs_n;
    wire next_spi = spi | to_spi;
    wire poll_done = int'(polls) + 1 >= READY_POLLS;
    wire next_ready = is_reset ? 1'b0 : (is_init && poll_done) | card_ready;
    wire spi_illegal = spi & is_bcast;
    wire [7:0] r1 = {5'h00, spi_illegal, 1'b0, ~next_ready};
    wire [47:0] next_tx = next_spi ? {r1, cbfe_pkg::SPI_FILL} : {2'h0, idx, next_ready, 31'h0, 7'h00, 1'b1};
    wire [5:0] next_len = next_spi ? cbfe_pkg::R1_BITS : cbfe_pkg::FRAME_BITS;
    // SD reset never answers; SPI answers every frame regardless of state
    wire respond = frame_ok & (next_spi | ~is_reset);
    wire do_bit = (spi & tx_drive) ? tx_bit : ~busy_q;

    assign link.cmd_d_out = tx_bit;
    assign link.cmd_d_oe = tx_drive & ~spi;
    assign link.dat_d_out = {3'h7, do_bit};
    // Lines 1-3 stay inputs; no wide transfer is driven from this end
    assign link.dat_d_oe = {3'h0, spi ? ~cs_n : busy_q};
    assign link.cd_pull = cd_pull_en;
    assign bus_mode = mode;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            sclk_s <= 2'h0;
            cmd_s <= 2'h3;
            cs_s <= 2'h3;
            vdd_s <= 2'h0;
            sclk_q <= 1'b0;
            vdd_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            sclk_s <= {sclk_s[0], link.sclk};
            cmd_s <= {cmd_s[0], link.cmd};
            cs_s <= {cs_s[0], link.dat[3]};
            vdd_s <= {vdd_s[0], vdd_ok};
            sclk_q <= sclk_s[1];
            vdd_q <= vdd_s[1];
            busy_q <= prog_busy;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (core_rst || deselected)
        begin
            rx_on <= 1'b0;
            rx_cnt <= 6'h00;
            bitpos <= 3'h0;
        end
        else if (rise)
        begin
            bitpos <= bitpos + 3'h1;
            if (rx_start)
            begin
                rx_on <= 1'b1;
                rx_cnt <= 6'h01;
            end
            else if (rx_on)
            begin
                rx_cnt <= rx_cnt + 6'h01;
                rx_on <= ~rx_last;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            rx_shift <= 47'h0;
        else if (rise)
            rx_shift <= {rx_shift[45:0], line};
    end

    always_ff @(posedge sys_clk)
    begin
        if (core_rst)
        begin
            mode <= cbfe_pkg::CBFE_SD_OPEN;
            app_cmd <= 1'b0;
            polls <= 8'h00;
            card_ready <= 1'b0;
            bus_wide <= 1'b0;
            speed_mode <= 3'h0;
            cd_pull_en <= 1'b1;
            cmd_valid <= 1'b0;
            cmd_index <= 6'h00;
            cmd_arg <= 32'h0;
        end
        else
        begin
            // No new flash access is issued while the supply is low
            cmd_valid <= frame_ok & vdd_s[1];
            if (frame_ok)
            begin
                cmd_index <= idx;
                cmd_arg <= arg;
                app_cmd <= ~app_cmd & idx == cbfe_pkg::CMD_APP;
                card_ready <= next_ready;
                if (to_spi)
                    mode <= cbfe_pkg::CBFE_SPI;
                else if (mode == cbfe_pkg::CBFE_SD_OPEN && is_reset)
                    mode <= cbfe_pkg::CBFE_SD;
                if (is_reset)
                begin
                    polls <= 8'h00;
                    bus_wide <= 1'b0;
                end
                else if (is_init && !card_ready)
                    polls <= polls + 8'h01;
                if (is_width)
                    bus_wide <= arg[1:0] == cbfe_pkg::WIDTH_4BIT;
                if (is_cd)
                    cd_pull_en <= arg[0];
                if (is_switch)
                    speed_mode <= arg[2:0];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (core_rst || deselected)
        begin
            tx_shift <= 48'h0;
            tx_left <= 6'h00;
            tx_bit <= 1'b1;
            tx_drive <= 1'b0;
        end
        else if (respond)
        begin
            tx_shift <= next_tx;
            tx_left <= next_len;
        end
        else if (fall && tx_left != 6'h00)
        begin
            tx_bit <= tx_shift[47];
            tx_shift <= {tx_shift[46:0], 1'b1};
            tx_left <= tx_left - 6'h01;
            tx_drive <= 1'b1;
        end
        else if (fall)
        begin
            tx_bit <= 1'b1;
            tx_drive <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/cbfe_pkg.sv
// Purpose: Shared constants and types of the card bus front end
// Assumes: Command frames of 48 bits in both bus modes; SPI responses of 8 bits
// Notes: Command codes are the card command indices
package cbfe_pkg;
    localparam logic [5:0] FRAME_BITS = 6'h30;
    localparam logic [5:0] R1_BITS = 6'h08;
    localparam logic [6:0] INIT_CLOCKS = 7'h4a;
    localparam logic [7:0] RESP_TIMEOUT = 8'h40;
    localparam logic [5:0] CMD_RESET = 6'h00;
    localparam logic [5:0] CMD_OP_COND1 = 6'h01;
    localparam logic [5:0] CMD_SEND_ID = 6'h02;
    localparam logic [5:0] CMD_REL_ADDR = 6'h03;
    localparam logic [5:0] CMD_SWITCH = 6'h06;
    localparam logic [5:0] CMD_APP = 6'h37;
    localparam logic [5:0] ACMD_BUS_WIDTH = 6'h06;
    localparam logic [5:0] ACMD_OP_COND = 6'h29;
    localparam logic [5:0] ACMD_CARD_DETECT = 6'h2a;
    localparam logic [1:0] WIDTH_4BIT = 2'h2;
    localparam logic [3:0] SPEED_MAX = 4'h4;
    localparam logic [39:0] SPI_FILL = 40'hff_ffff_ffff;
    typedef enum logic [2:0] {
        CBFE_SD_OPEN = 3'b001,
        CBFE_SD = 3'b010,
        CBFE_SPI = 3'b100
    } cbfe_mode_t;
    typedef enum logic [4:0] {
        H_INIT = 5'b00001,
        H_IDLE = 5'b00010,
        H_SEND = 5'b00100,
        H_WAIT = 5'b01000,
        H_RECV = 5'b10000
    } cbfe_hstate_t;
endpackage

// ===== hdl/cbfe_link_if.sv
// Purpose: Card bus pins between host end and card end
// Assumes: Undriven lines read high through bus pull-ups
// Notes: dat[0] doubles as SPI data out, cmd as SPI data in, dat[3] as chip select
`timescale 1ns/10ps
`default_nettype none
interface cbfe_link_if;
    logic sclk;
    logic cmd_h_out;
    logic cmd_h_oe;
    logic cmd_d_out;
    logic cmd_d_oe;
    logic [3:0] dat_h_out;
    logic [3:0] dat_h_oe;
    logic [3:0] dat_d_out;
    logic [3:0] dat_d_oe;
    logic cd_pull;
    logic cmd;
    logic [3:0] dat;
    assign cmd = cmd_h_oe ? cmd_h_out : (cmd_d_oe ? cmd_d_out : 1'b1);
    assign dat = (dat_h_oe & dat_h_out) | (dat_d_oe & dat_d_out) | ~(dat_h_oe | dat_d_oe);
    modport host (
        output sclk, cmd_h_out, cmd_h_oe, dat_h_out, dat_h_oe,
        input cmd, dat, cd_pull
    );
    modport card (
        input sclk, cmd, dat,
        output cmd_d_out, cmd_d_oe, dat_d_out, dat_d_oe, cd_pull
    );
endinterface
`default_nettype wire

// ===== hdl/cbfe_host.sv
// Purpose: Host end: clock generation, init clocks, command and response
// Assumes: spi_mode stays stable from reset onward
// Notes: CRC field sent as zero; card end does not check it
`timescale 1ns/10ps
`default_nettype none
module cbfe_host #(
    parameter int HALF_PERIOD = 10
) (
    input wire logic sys_clk,
    input wire logic nrst,
    cbfe_link_if.host link,
    input wire logic spi_mode,
    input wire logic req,
    input wire logic [5:0] req_index,
    input wire logic [31:0] req_arg,
    output logic host_idle,
    output logic resp_valid,
    output logic [47:0] resp_data,
    output logic resp_timeout,
    output logic card_present
);
    cbfe_pkg::cbfe_hstate_t state;
    logic [7:0] div;
    logic sclk;
    logic [1:0] cmd_s;
    logic [1:0] do_s;
    logic [1:0] cd_s;
    logic [47:0] shift;
    logic [6:0] cnt;
    logic [2:0] bitpos;
    logic [7:0] timer;
    logic cs_n;
    logic cmd_out;
    logic cmd_oe;

    wire running = state != cbfe_pkg::H_IDLE;
    wire tick = running && div == 8'(HALF_PERIOD - 1);
    wire rise_en = tick & ~sclk;
    wire fall_en = tick & sclk;
    wire line = spi_mode ? do_s[1] : cmd_s[1];
    wire [6:0] resp_len = spi_mode ? {1'b0, cbfe_pkg::R1_BITS} : {1'b0, cbfe_pkg::FRAME_BITS};
    wire [47:0] req_frame = {2'h1, req_index, req_arg, 7'h00, 1'b1};
    wire hunt_ok = (~spi_mode | bitpos == 3'h0) & ~line;
    wire recv_end = cnt + 7'h01 == resp_len;

    assign link.sclk = sclk;
    assign link.cmd_h_out = cmd_out;
    assign link.cmd_h_oe = cmd_oe;
    // Lines 0 to 2 never driven; in SD mode line 3 floats high
    assign link.dat_h_out = {cs_n, 3'h7};
    assign link.dat_h_oe = {spi_mode, 3'h0};
    assign host_idle = state == cbfe_pkg::H_IDLE;
    assign card_present = cd_s[1];

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cmd_s <= 2'h3;
            do_s <= 2'h3;
            cd_s <= 2'h0;
        end
        else
        begin
            cmd_s <= {cmd_s[0], link.cmd};
            do_s <= {do_s[0], link.dat[0]};
            cd_s <= {cd_s[0], link.cd_pull};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            div <= 8'h00;
            sclk <= 1'b0;
        end
        else
        begin
            div <= (running && !tick) ? div + 8'h01 : 8'h00;
            if (resp_valid || resp_timeout)
                sclk <= 1'b0;
            else if (tick)
                sclk <= ~sclk;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state <= cbfe_pkg::H_INIT;
            shift <= 48'h0;
            cnt <= 7'h00;
            bitpos <= 3'h0;
            timer <= 8'h00;
            cs_n <= 1'b1;
            cmd_out <= 1'b1;
            cmd_oe <= 1'b1;
            resp_valid <= 1'b0;
            resp_timeout <= 1'b0;
            resp_data <= 48'h0;
        end
        else
        begin
            resp_valid <= 1'b0;
            resp_timeout <= 1'b0;
            if (rise_en)
                bitpos <= bitpos + 3'h1;
            case (state)
                cbfe_pkg::H_INIT:
                begin
                    // Clocks with chip select high before the first command
                    if (rise_en)
                        cnt <= cnt + 7'h01;
                    if (fall_en && cnt == cbfe_pkg::INIT_CLOCKS)
                        state <= cbfe_pkg::H_IDLE;
                end
                cbfe_pkg::H_IDLE:
                begin
                    if (req)
                    begin
                        cs_n <= ~spi_mode;
                        cmd_out <= req_frame[47];
                        cmd_oe <= 1'b1;
                        shift <= {req_frame[46:0], 1'b1};
                        cnt <= 7'h01;
                        bitpos <= 3'h0;
                        timer <= 8'h00;
                        state <= cbfe_pkg::H_SEND;
                    end
                end
                cbfe_pkg::H_SEND:
                begin
                    if (fall_en && cnt == {1'b0, cbfe_pkg::FRAME_BITS})
                    begin
                        cmd_out <= 1'b1;
                        cmd_oe <= spi_mode;
                        state <= cbfe_pkg::H_WAIT;
                    end
                    else if (fall_en)
                    begin
                        cmd_out <= shift[47];
                        shift <= {shift[46:0], 1'b1};
                        cnt <= cnt + 7'h01;
                    end
                end
                cbfe_pkg::H_WAIT:
                begin
                    if (rise_en && hunt_ok)
                    begin
                        shift <= 48'h0;
                        cnt <= 7'h01;
                        state <= cbfe_pkg::H_RECV;
                    end
                    else if (rise_en && timer == cbfe_pkg::RESP_TIMEOUT)
                    begin
                        resp_timeout <= 1'b1;
                        cs_n <= 1'b1;
                        cmd_oe <= 1'b1;
                        state <= cbfe_pkg::H_IDLE;
                    end
                    else if (rise_en)
                        timer <= timer + 8'h01;
                end
                cbfe_pkg::H_RECV:
                begin
                    if (rise_en)
                    begin
                        shift <= {shift[46:0], line};
                        cnt <= cnt + 7'h01;
                        if (recv_end)
                        begin
                            resp_valid <= 1'b1;
                            resp_data <= {shift[46:0], line};
                            cs_n <= 1'b1;
                            // Card still drives its stop bit here; cmd is taken back at the next request
                            state <= cbfe_pkg::H_IDLE;
                        end
                    end
                end
                default:
                    state <= cbfe_pkg::H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verification/cbfe_link_properties.sv
// Purpose: Wire-level checks on the link between host end and card end
// Assumes: SPI select is dat_h_out[3] while dat_h_oe[3] is high
// Notes: Sees only the link signals, so mode is read from the select drive
`timescale 1ns/10ps
`default_nettype none
module cbfe_link_properties #(
    parameter int HALF_PERIOD = 10
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cmd_h_out,
    input wire logic cmd_h_oe,
    input wire logic cmd_d_out,
    input wire logic cmd_d_oe,
    input wire logic [3:0] dat_h_out,
    input wire logic [3:0] dat_h_oe,
    input wire logic [3:0] dat_d_oe,
    input wire logic cd_pull
);
    logic sclk_q;
    logic [7:0] stand;
    wire sel = dat_h_oe[3] & ~dat_h_out[3];
    // Cycles sclk has stood since its last change
    always_ff @(posedge sys_clk)
    begin
        sclk_q <= sclk;
        if (!nrst || sclk != sclk_q)
            stand <= 8'h00;
        else if (stand != 8'hff)
            stand <= stand + 8'h01;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    chk_upper_lines_in: assert property (dat_d_oe[3:1] == 3'h0)
        else $error("card drives data lines 1 to 3");
    chk_host_upper_in: assert property (dat_h_oe[2:1] == 2'h0)
        else $error("host drives data lines 1 to 2");
    chk_cmd_one_driver: assert property (!(cmd_h_oe && cmd_d_oe))
        else $error("both ends drive cmd");
    chk_card_start_bit: assert property ($rose(cmd_d_oe) |-> !cmd_d_out)
        else $error("response without start bit");
    chk_card_stop_bit: assert property ($fell(cmd_d_oe) |-> $past(cmd_d_out))
        else $error("response without stop bit");
    chk_host_stop_bit: assert property ($fell(cmd_h_oe) |-> $past(cmd_h_out))
        else $error("command without stop bit");
    // Card sees select through two flip-flops, so its drive trails select by two cycles
    chk_do_when_sel: assert property (dat_d_oe[0] && dat_h_oe[3] |-> $past(sel, 2))
        else $error("data out driven while deselected");
    chk_sel_held: assert property ($rose(sel) |-> sel [*8])
        else $error("select dropped early");
    chk_sclk_half: assert property (sclk && !sclk_q |-> int'(stand) >= HALF_PERIOD - 1)
        else $error("link clock low phase too short");
    cover property ($fell(cd_pull));
    cover property ($rose(cmd_d_oe));
    cover property ($rose(dat_d_oe[0]) && sel);
endmodule
`default_nettype wire

// ===== verification/card_bus_mode_front_end_test.sv
// Purpose: Self-checking bench of host end and card end on one link
// Assumes: Host half period of 10 sys_clk cycles
// Notes: Power drop is played through vdd_ok
`timescale 1ns/10ps
`default_nettype none
module card_bus_mode_front_end_test;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic vdd_ok = 1'b1;
    logic prog_busy = 1'b0;
    logic spi_mode = 1'b0;
    logic req = 1'b0;
    logic [5:0] req_index = 6'h00;
    logic [31:0] req_arg = 32'h0;
    logic host_idle, resp_valid, resp_timeout, card_present;
    logic cmd_valid, bus_wide, card_ready;
    logic [47:0] resp_data, eq, mq;
    logic [5:0] cmd_index;
    logic [31:0] cmd_arg;
    logic [2:0] speed_mode;
    logic [1:0] kq;
    cbfe_pkg::cbfe_mode_t bus_mode;
    int err_count = 0;
    int compares = 0;
    bit vlow = 1'b0;
    logic [1:0] ekind[$];
    logic [47:0] eresp[$];
    logic [47:0] emask[$];
    logic [37:0] ecmd[$];
    localparam logic [47:0] SDM = 48'hff7f_ffff_ffff;
    cbfe_link_if i_cbfe_link_if ();
    cbfe_host #(.HALF_PERIOD(10)) i_cbfe_host (.sys_clk(sys_clk), .nrst(nrst), .link(i_cbfe_link_if),
        .spi_mode(spi_mode), .req(req), .req_index(req_index), .req_arg(req_arg), .host_idle(host_idle),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_timeout(resp_timeout), .card_present(card_present));
    // One card only on the shared link, as high speed mode demands
    cbfe_card #(.READY_POLLS(2)) i_cbfe_card (.sys_clk(sys_clk), .nrst(nrst), .link(i_cbfe_link_if),
        .vdd_ok(vdd_ok), .prog_busy(prog_busy), .cmd_valid(cmd_valid), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
        .bus_mode(bus_mode), .bus_wide(bus_wide), .speed_mode(speed_mode), .card_ready(card_ready));
    cbfe_link_properties #(.HALF_PERIOD(10)) i_cbfe_link_properties (.sys_clk(sys_clk), .nrst(nrst),
        .sclk(i_cbfe_link_if.sclk), .cmd_h_out(i_cbfe_link_if.cmd_h_out), .cmd_h_oe(i_cbfe_link_if.cmd_h_oe),
        .cmd_d_out(i_cbfe_link_if.cmd_d_out), .cmd_d_oe(i_cbfe_link_if.cmd_d_oe),
        .dat_h_out(i_cbfe_link_if.dat_h_out), .dat_h_oe(i_cbfe_link_if.dat_h_oe),
        .dat_d_oe(i_cbfe_link_if.dat_d_oe), .cd_pull(i_cbfe_link_if.cd_pull));
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic fail(input string s);
        $display("[FAIL] %0t %s", $time, s);
        err_count++;
    endtask
    task automatic chk_resp(input logic [1:0] k, input logic [47:0] e, input logic [47:0] m);
        compares++;
        if ({resp_timeout, resp_data & m} !== {k[0], e & m})
            fail("response mismatch");
    endtask
    task automatic chk_cmd(input logic [37:0] e);
        compares++;
        if ({cmd_index, cmd_arg} !== e)
            fail("received command mismatch");
    endtask
    task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
            fail("status mismatch");
    endtask
    task automatic print_verdict;
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic idle_wait;
        int n;
        n = 0;
        while (host_idle !== 1'b1 && n < 6000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 6000)
        begin
            fail("host hang");
            print_verdict();
        end
    endtask
    // Kind 0 response, 1 timeout, 2 either
    task automatic go(input logic [5:0] ix, input logic [31:0] ag, input logic [1:0] k,
                      input logic [47:0] e, input logic [47:0] m);
        idle_wait();
        ekind.push_back(k);
        eresp.push_back(e);
        emask.push_back(m);
        if (!vlow)
            ecmd.push_back({ix, ag});
        req <= 1'b1;
        req_index <= ix;
        req_arg <= ag;
        @(posedge sys_clk);
        req <= 1'b0;
        @(posedge sys_clk);
        idle_wait();
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic cm(input logic [5:0] ix, input logic [31:0] ag, input logic [7:0] r1);
        if (spi_mode)
            go(ix, ag, 2'h0, {40'h0, r1}, 48'hffff_ffff_fffe);
        else
            go(ix, ag, 2'h0, {2'h0, ix, 40'h1}, SDM);
    endtask
    always @(posedge sys_clk)
    begin
        if (nrst && (resp_valid === 1'b1 || resp_timeout === 1'b1))
        begin
            if (ekind.size() == 0)
                fail("unexpected response");
            else
            begin
                kq = ekind.pop_front();
                eq = eresp.pop_front();
                mq = emask.pop_front();
                if (kq != 2'h2)
                    chk_resp(kq, eq, mq);
            end
        end
        if (nrst && cmd_valid === 1'b1)
        begin
            if (ecmd.size() == 0)
                fail("unexpected command");
            else
                chk_cmd(ecmd.pop_front());
        end
    end
    initial
    begin
        void'($urandom(32'hf602));
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        idle_wait();
        chk_val({5'h0, bus_mode}, {5'h0, cbfe_pkg::CBFE_SD_OPEN});
        chk_val({7'h0, card_present}, 8'h01);
        go(cbfe_pkg::CMD_RESET, 32'h0, 2'h1, 48'h0, 48'h0);
        chk_val({5'h0, bus_mode}, {5'h0, cbfe_pkg::CBFE_SD});
        cm(cbfe_pkg::CMD_APP, 32'h0, 8'h0);
        cm(cbfe_pkg::ACMD_BUS_WIDTH, 32'h2, 8'h0);
        chk_val({7'h0, bus_wide}, 8'h00);
        repeat (3)
        begin
            cm(cbfe_pkg::CMD_APP, 32'h0, 8'h0);
            cm(cbfe_pkg::ACMD_OP_COND, 32'h0, 8'h0);
        end
        chk_val({7'h0, card_ready}, 8'h01);
        cm(cbfe_pkg::CMD_APP, 32'h0, 8'h0);
        cm(cbfe_pkg::ACMD_BUS_WIDTH, 32'h2, 8'h0);
        chk_val({7'h0, bus_wide}, 8'h01);
        for (int s = 0; s < 6; s++)
        begin
            cm(cbfe_pkg::CMD_SWITCH, {1'b1, 27'h0, 4'(s)}, 8'h0);
            chk_val({5'h0, speed_mode}, (s > 4) ? 8'h04 : 8'(s));
        end
        cm(cbfe_pkg::CMD_APP, 32'h0, 8'h0);
        cm(cbfe_pkg::ACMD_CARD_DETECT, 32'h0, 8'h0);
        chk_val({7'h0, card_present}, 8'h00);
        repeat (3) cm(cbfe_pkg::CMD_SEND_ID, $urandom(), 8'h0);
        go(cbfe_pkg::CMD_RESET, 32'h0, 2'h1, 48'h0, 48'h0);
        chk_val({5'h0, bus_mode}, {5'h0, cbfe_pkg::CBFE_SD});
        // Supply dip: no command may reach the user side
        vdd_ok <= 1'b0;
        vlow = 1'b1;
        go(cbfe_pkg::CMD_APP, 32'h0, 2'h2, 48'h0, 48'h0);
        vlow = 1'b0;
        vdd_ok <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk_val({2'h0, bus_mode, card_ready, bus_wide, card_present}, {2'h0, cbfe_pkg::CBFE_SD_OPEN, 3'h1});
        nrst <= 1'b0;
        spi_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        go(cbfe_pkg::CMD_RESET, 32'h0, 2'h0, 48'h1, 48'hffff_ffff_ffff);
        chk_val({5'h0, bus_mode}, {5'h0, cbfe_pkg::CBFE_SPI});
        cm(cbfe_pkg::CMD_SEND_ID, 32'h0, 8'h04);
        cm(cbfe_pkg::CMD_REL_ADDR, $urandom(), 8'h04);
        cm(cbfe_pkg::CMD_RESET, 32'h0, 8'h01);
        repeat (3)
        begin
            cm(cbfe_pkg::CMD_APP, 32'h0, 8'h0);
            cm(cbfe_pkg::ACMD_OP_COND, 32'h0, 8'h0);
        end
        chk_val({3'h0, bus_mode, card_ready, 1'b0}, {3'h0, cbfe_pkg::CBFE_SPI, 2'h2});
        // Restart as the other card type: reset, then the older init command until ready
        cm(cbfe_pkg::CMD_RESET, 32'h0, 8'h01);
        go(cbfe_pkg::CMD_OP_COND1, 32'h0, 2'h0, 48'h1, 48'hffff_ffff_ffff);
        go(cbfe_pkg::CMD_OP_COND1, 32'h0, 2'h0, 48'h0, 48'hffff_ffff_ffff);
        cm(cbfe_pkg::CMD_APP, 32'h0, 8'h0);
        go(cbfe_pkg::ACMD_BUS_WIDTH, 32'h2, 2'h0, 48'h0, 48'h0);
        chk_val({7'h0, bus_wide}, 8'h00);
        // Programming while deselected must leave data out released
        prog_busy <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_val({7'h0, i_cbfe_link_if.dat[0]}, 8'h01);
        prog_busy <= 1'b0;
        cm(cbfe_pkg::CMD_SEND_ID, 32'h0, 8'h04);
        if (ekind.size() != 0 || ecmd.size() != 0)
            fail("expected result never seen");
        print_verdict();
    end
endmodule
`default_nettype wire
